// ===== sched_pkg.sv
package sched_pkg;
   typedef logic [31:0] word_t;

   // empty list marker; also the reset value of every list pointer
   localparam word_t NIL_PTR = 32'h8000_0000;
   localparam int NIB_W = 4;
   localparam int BYTES_PER_WORD = 4;

   // function codes (upper nibble of each instruction byte)
   localparam logic [3:0] FN_JUMP = 4'h0;
   localparam logic [3:0] FN_PFIX = 4'h2;
   localparam logic [3:0] FN_LDC = 4'h4;
   localparam logic [3:0] FN_NFIX = 4'h6;
   localparam logic [3:0] FN_OPR = 4'hF;

   // operation selectors carried by the operate function
   localparam word_t OP_ENDP = 32'h0000_0003;
   localparam word_t OP_ADD = 32'h0000_0005;
   localparam word_t OP_STARTP = 32'h0000_000D;
   localparam word_t OP_STOPP = 32'h0000_0015;

   // workspace layout, word offsets
   localparam word_t WS_IPTR_BELOW = 32'h0000_0001;
   localparam word_t WS_LINK_BELOW = 32'h0000_0002;
   localparam word_t PAR_IPTR_OFS = 32'h0000_0000;
   localparam word_t PAR_COUNT_OFS = 32'h0000_0001;

   localparam logic PRI_HIGH = 1'b0;
   localparam logic PRI_LOW = 1'b1;

   // timing
   localparam int CLK_PERIOD_NS = 8;
   localparam int SLICE_INPUT_CYCLES = 5120;
   localparam int SLICES_MAX = 2;
   localparam int SWITCH_TIME_NS = 1000;
   localparam int SWITCH_MAX_CYCLES = SWITCH_TIME_NS / CLK_PERIOD_NS;

   typedef enum logic [3:0] {
      S_IDLE, S_EXEC, S_SAVE, S_ENQ, S_PICK, S_LOAD_IP, S_LOAD_LINK,
      S_START_WR, S_ENDP_RD, S_ENDP_WR, S_ENDP_IP
   } sched_state_t;
endpackage : sched_pkg

// ===== slice_tick_gen.sv
`timescale 1ns/100ps
module slice_tick_gen #(
   parameter int SLICE_EDGES = 5120
) (
   input wire logic core_clk,
   input wire logic rst,
   input wire logic ext_clk_in,
   output logic tick
);
   import sched_pkg::*;

   logic sync1_q, sync2_q, sync3_q;
   logic [15:0] cnt_q;
   wire rise_w = sync2_q & ~sync3_q;

   if (SLICE_EDGES < 2 || SLICE_EDGES > 65535) begin : g_chk
      $error("slice_tick_gen: SLICE_EDGES out of range");
   end

   // two-stage sync; edge detect only looks past the first stage
   always_ff @(posedge core_clk or posedge rst) begin
      if (rst) begin
         sync1_q <= 1'b0;
         sync2_q <= 1'b0;
         sync3_q <= 1'b0;
      end else begin
         sync1_q <= ext_clk_in;
         sync2_q <= sync1_q;
         sync3_q <= sync2_q;
      end
   end

   // one pulse per slice of input clock rising edges
   always_ff @(posedge core_clk or posedge rst) begin
      if (rst) begin
         cnt_q <= 16'h0000;
         tick <= 1'b0;
      end else begin
         tick <= 1'b0;
         if (rise_w) begin
            if (cnt_q == 16'(SLICE_EDGES - 1)) begin
               cnt_q <= 16'h0000;
               tick <= 1'b1;
            end else begin
               cnt_q <= cnt_q + 16'h0001;
            end
         end
      end
   end
endmodule : slice_tick_gen

// ===== insn_prefetch.sv
`timescale 1ns/100ps
module insn_prefetch (
   input wire logic core_clk,
   input wire logic rst,
   input sched_pkg::word_t iptr,
   input wire logic flush,
   input wire logic take,
   output logic byte_valid,
   output logic [7:0] byte_out,
   output logic ifetch_req,
   output sched_pkg::word_t ifetch_addr,
   input wire logic ifetch_ack,
   input sched_pkg::word_t ifetch_rdata
);
   import sched_pkg::*;

   word_t cur_q, nxt_q, cur_addr_q;
   logic cur_v_q, nxt_v_q, discard_q;
   wire got_w = ifetch_ack & ifetch_req & ~discard_q;
   wire shift_w = take & (iptr[1:0] == 2'h3);

   // byte lane of the executing word picked by the low address bits
   assign byte_valid = cur_v_q & (cur_addr_q == {2'b00, iptr[31:2]});
   assign byte_out = cur_q[8 * iptr[1:0] +: 8];

   // one word executing plus one word fetched ahead
   always_ff @(posedge core_clk or posedge rst) begin
      if (rst) begin
         cur_q <= 32'h0000_0000;
         nxt_q <= 32'h0000_0000;
         cur_addr_q <= 32'h0000_0000;
         cur_v_q <= 1'b0;
         nxt_v_q <= 1'b0;
         discard_q <= 1'b0;
         ifetch_req <= 1'b0;
         ifetch_addr <= 32'h0000_0000;
      end else if (flush) begin
         cur_v_q <= 1'b0;
         nxt_v_q <= 1'b0;
         // a fetch in flight must finish; its data is dropped
         discard_q <= ifetch_req & ~ifetch_ack & ~discard_q | discard_q & ~ifetch_ack;
         if (ifetch_ack) ifetch_req <= 1'b0;
      end else begin
         if (ifetch_ack) begin
            ifetch_req <= 1'b0;
            discard_q <= 1'b0;
         end else if (!ifetch_req && !(cur_v_q && nxt_v_q)) begin
            ifetch_req <= 1'b1;
            ifetch_addr <= cur_v_q ? cur_addr_q + 32'h1 : {2'b00, iptr[31:2]};
         end
         if (shift_w) begin
            cur_q <= nxt_v_q ? nxt_q : ifetch_rdata;
            cur_v_q <= nxt_v_q | got_w;
            cur_addr_q <= cur_addr_q + 32'h1;
            nxt_q <= ifetch_rdata;
            nxt_v_q <= nxt_v_q & got_w;
         end else if (got_w && !cur_v_q) begin
            cur_q <= ifetch_rdata;
            cur_v_q <= 1'b1;
            cur_addr_q <= ifetch_addr;
         end else if (got_w) begin
            nxt_q <= ifetch_rdata;
            nxt_v_q <= 1'b1;
         end
      end
   end
endmodule : insn_prefetch

// ===== process_scheduler_operate_decode.sv
`timescale 1ns/100ps
module process_scheduler_operate_decode #(
   parameter int SLICE_EDGES = sched_pkg::SLICE_INPUT_CYCLES
) (
   input wire logic core_clk,
   input wire logic rst,
   input wire logic ext_clk_in,
   output logic ifetch_req,
   output sched_pkg::word_t ifetch_addr,
   input wire logic ifetch_ack,
   input sched_pkg::word_t ifetch_rdata,
   output logic dmem_req,
   output logic dmem_we,
   output sched_pkg::word_t dmem_addr,
   output sched_pkg::word_t dmem_wdata,
   input wire logic dmem_ack,
   input sched_pkg::word_t dmem_rdata,
   input wire logic wake_valid,
   input sched_pkg::word_t wake_wptr,
   input wire logic wake_pri,
   output logic wake_ready,
   output logic idle,
   output logic running_pri,
   output sched_pkg::word_t running_wptr,
   output sched_pkg::word_t iptr,
   output sched_pkg::word_t oreg,
   output sched_pkg::word_t stack_a,
   output sched_pkg::word_t stack_b,
   output sched_pkg::word_t stack_c,
   output sched_pkg::word_t high_pri_list_front,
   output sched_pkg::word_t high_pri_list_back,
   output sched_pkg::word_t low_pri_list_front,
   output sched_pkg::word_t low_pri_list_back
);
   import sched_pkg::*;

   if (SLICE_EDGES < 2) begin : g_chk
      $error("process_scheduler_operate_decode: SLICE_EDGES too small");
   end

   function automatic word_t ws_slot(input word_t base, input word_t below);
      ws_slot = base - below;
   endfunction : ws_slot

   sched_state_t state_q, ret_q;
   word_t front_q [2];
   word_t back_q [2];
   word_t wptr_q, iptr_q, oreg_q, a_q, b_q, c_q, tmp_q, enq_w_q, pick_w_q;
   logic pri_q, enq_pri_q, pick_pri_q, requeue_q, flush_q;
   logic [1:0] slices_q;
   logic req_q, we_q, wake_ready_q;
   word_t addr_q, wdata_q;

   logic byte_valid, tick;
   logic [7:0] cur_byte;

   // decode of the current byte
   wire [3:0] fn_w = cur_byte[7:4];
   wire [3:0] nib_w = cur_byte[3:0];
   wire word_t opnd_w = oreg_q | {28'h0, nib_w};
   wire is_pfix_w = fn_w == FN_PFIX;
   wire is_nfix_w = fn_w == FN_NFIX;
   wire is_opr_w = fn_w == FN_OPR;
   wire op_add_w = is_opr_w & (opnd_w == OP_ADD);
   wire op_startp_w = is_opr_w & (opnd_w == OP_STARTP);
   wire op_endp_w = is_opr_w & (opnd_w == OP_ENDP);
   wire op_stopp_w = is_opr_w & (opnd_w == OP_STOPP);
   wire is_jump_w = fn_w == FN_JUMP;
   wire word_t ip_next_w = iptr_q + 32'h1;

   // descheduling at a jump: low process over its slices or high work waiting
   wire slice_due_w = (pri_q == PRI_LOW) &&
      (slices_q >= 2'(SLICES_MAX) || front_q[PRI_HIGH] != NIL_PTR);

   wire wake_take_w = wake_valid & wake_ready_q & (state_q == S_IDLE || state_q == S_EXEC);
   // no byte runs in the flush cycle: the buffer may still show the old stream
   wire exec_w = (state_q == S_EXEC) & byte_valid & ~wake_take_w & ~flush_q;
   wire leave_w = exec_w & (op_startp_w | op_endp_w | op_stopp_w | is_jump_w & slice_due_w);

   // high list first; low only when high is empty
   wire pick_hi_w = front_q[PRI_HIGH] != NIL_PTR;
   wire pick_lo_w = front_q[PRI_LOW] != NIL_PTR;
   wire enq_empty_w = front_q[enq_pri_q] == NIL_PTR;

   // data memory address, write flag and data per state
   wire word_t mem_addr_w =
      (state_q == S_SAVE) ? ws_slot(wptr_q, WS_IPTR_BELOW) :
      (state_q == S_ENQ) ? ws_slot(back_q[enq_pri_q], WS_LINK_BELOW) :
      (state_q == S_LOAD_IP) ? ws_slot(pick_w_q, WS_IPTR_BELOW) :
      (state_q == S_LOAD_LINK) ? ws_slot(pick_w_q, WS_LINK_BELOW) :
      (state_q == S_START_WR) ? ws_slot(a_q, WS_IPTR_BELOW) :
      (state_q == S_ENDP_IP) ? a_q + PAR_IPTR_OFS : a_q + PAR_COUNT_OFS;
   wire mem_we_w = state_q == S_SAVE || state_q == S_ENQ ||
      state_q == S_START_WR || state_q == S_ENDP_WR;
   wire word_t mem_wdata_w = (state_q == S_SAVE) ? iptr_q :
      (state_q == S_ENQ) ? enq_w_q : tmp_q;
   wire mem_done_w = req_q & dmem_ack;

   insn_prefetch u_prefetch (
      .core_clk(core_clk),
      .rst(rst),
      .iptr(iptr_q),
      .flush(flush_q),
      .take(exec_w),
      .byte_valid(byte_valid),
      .byte_out(cur_byte),
      .ifetch_req(ifetch_req),
      .ifetch_addr(ifetch_addr),
      .ifetch_ack(ifetch_ack),
      .ifetch_rdata(ifetch_rdata)
   );

   slice_tick_gen #(.SLICE_EDGES(SLICE_EDGES)) u_tick (
      .core_clk(core_clk),
      .rst(rst),
      .ext_clk_in(ext_clk_in),
      .tick(tick)
   );

   // data memory request: held until acknowledged
   always_ff @(posedge core_clk or posedge rst) begin
      if (rst) begin
         req_q <= 1'b0;
         we_q <= 1'b0;
         addr_q <= 32'h0000_0000;
         wdata_q <= 32'h0000_0000;
      end else if (mem_done_w) begin
         req_q <= 1'b0;
      end else if (!req_q && state_q >= S_SAVE && state_q != S_PICK &&
                   !(state_q == S_ENQ && enq_empty_w)) begin
         req_q <= 1'b1;
         we_q <= mem_we_w;
         addr_q <= mem_addr_w;
         wdata_q <= mem_wdata_w;
      end
   end

   // slice count of the running low process
   always_ff @(posedge core_clk or posedge rst) begin
      if (rst) begin
         slices_q <= 2'h0;
      end else if (state_q == S_LOAD_IP) begin
         slices_q <= 2'h0;
      end else if (tick && slices_q != 2'h3) begin
         slices_q <= slices_q + 2'h1;
      end
   end

   // instruction execution and scheduler sequencing
   always_ff @(posedge core_clk or posedge rst) begin
      if (rst) begin
         state_q <= S_IDLE;
         ret_q <= S_IDLE;
         front_q[0] <= NIL_PTR;
         front_q[1] <= NIL_PTR;
         back_q[0] <= NIL_PTR;
         back_q[1] <= NIL_PTR;
         wptr_q <= NIL_PTR;
         iptr_q <= 32'h0000_0000;
         oreg_q <= 32'h0000_0000;
         a_q <= 32'h0000_0000;
         b_q <= 32'h0000_0000;
         c_q <= 32'h0000_0000;
         tmp_q <= 32'h0000_0000;
         enq_w_q <= NIL_PTR;
         pick_w_q <= NIL_PTR;
         pri_q <= PRI_LOW;
         enq_pri_q <= PRI_HIGH;
         pick_pri_q <= PRI_HIGH;
         requeue_q <= 1'b0;
         flush_q <= 1'b0;
         wake_ready_q <= 1'b0;
      end else begin
         flush_q <= 1'b0;
         case (state_q)
            // nothing runnable: no instruction is executed
            S_IDLE: begin
               // ready must drop before the pick sequence, which refuses wakes
               wake_ready_q <= ~wake_take_w & ~pick_hi_w & ~pick_lo_w;
               if (wake_take_w) begin
                  enq_w_q <= wake_wptr;
                  enq_pri_q <= wake_pri;
                  ret_q <= S_PICK;
                  state_q <= S_ENQ;
               end else if (pick_hi_w || pick_lo_w) begin
                  state_q <= S_PICK;
               end
            end
            S_EXEC: begin
               wake_ready_q <= ~wake_take_w & ~leave_w;
               if (wake_take_w) begin
                  // a woken process queues; it never displaces the runner
                  enq_w_q <= wake_wptr;
                  enq_pri_q <= wake_pri;
                  ret_q <= S_EXEC;
                  state_q <= S_ENQ;
               end else if (exec_w) begin
                  iptr_q <= ip_next_w;
                  oreg_q <= 32'h0000_0000;
                  if (is_pfix_w) begin
                     oreg_q <= opnd_w << NIB_W;
                  end else if (is_nfix_w) begin
                     oreg_q <= (~opnd_w) << NIB_W;
                  end else if (fn_w == FN_LDC) begin
                     a_q <= opnd_w;
                     b_q <= a_q;
                     c_q <= b_q;
                  end else if (op_add_w) begin
                     a_q <= b_q + a_q;
                     b_q <= c_q;
                  end else if (is_jump_w) begin
                     iptr_q <= ip_next_w + opnd_w;
                     flush_q <= 1'b1;
                     if (slice_due_w) begin
                        requeue_q <= 1'b1;
                        state_q <= S_SAVE;
                     end
                  end else if (op_startp_w) begin
                     tmp_q <= ip_next_w + b_q;
                     state_q <= S_START_WR;
                  end else if (op_endp_w) begin
                     state_q <= S_ENDP_RD;
                  end else if (op_stopp_w) begin
                     requeue_q <= 1'b0;
                     state_q <= S_SAVE;
                  end
               end
            end
            // instruction pointer only; the stack is left as is
            S_SAVE: begin
               if (mem_done_w) begin
                  enq_w_q <= wptr_q;
                  enq_pri_q <= pri_q;
                  ret_q <= S_PICK;
                  state_q <= requeue_q ? S_ENQ : S_PICK;
               end
            end
            // append at the back: link the old back, then move back
            S_ENQ: begin
               if (enq_empty_w) begin
                  front_q[enq_pri_q] <= enq_w_q;
                  back_q[enq_pri_q] <= enq_w_q;
                  state_q <= ret_q;
               end else if (mem_done_w) begin
                  back_q[enq_pri_q] <= enq_w_q;
                  state_q <= ret_q;
               end
            end
            S_PICK: begin
               if (pick_hi_w) begin
                  pick_w_q <= front_q[PRI_HIGH];
                  pick_pri_q <= PRI_HIGH;
                  state_q <= S_LOAD_IP;
               end else if (pick_lo_w) begin
                  pick_w_q <= front_q[PRI_LOW];
                  pick_pri_q <= PRI_LOW;
                  state_q <= S_LOAD_IP;
               end else begin
                  wptr_q <= NIL_PTR;
                  state_q <= S_IDLE;
               end
            end
            S_LOAD_IP: begin
               if (mem_done_w) begin
                  iptr_q <= dmem_rdata;
                  if (front_q[pick_pri_q] == back_q[pick_pri_q]) begin
                     front_q[pick_pri_q] <= NIL_PTR;
                     back_q[pick_pri_q] <= NIL_PTR;
                     wptr_q <= pick_w_q;
                     pri_q <= pick_pri_q;
                     oreg_q <= 32'h0000_0000;
                     flush_q <= 1'b1;
                     state_q <= S_EXEC;
                  end else begin
                     state_q <= S_LOAD_LINK;
                  end
               end
            end
            S_LOAD_LINK: begin
               if (mem_done_w) begin
                  front_q[pick_pri_q] <= dmem_rdata;
                  wptr_q <= pick_w_q;
                  pri_q <= pick_pri_q;
                  oreg_q <= 32'h0000_0000;
                  flush_q <= 1'b1;
                  state_q <= S_EXEC;
               end
            end
            // new process: its start address goes below its workspace
            S_START_WR: begin
               if (mem_done_w) begin
                  enq_w_q <= a_q;
                  enq_pri_q <= pri_q;
                  ret_q <= S_EXEC;
                  state_q <= S_ENQ;
               end
            end
            // counter preset by the program before the components start
            S_ENDP_RD: begin
               if (mem_done_w) begin
                  tmp_q <= dmem_rdata - 32'h1;
                  state_q <= S_ENDP_WR;
               end
            end
            S_ENDP_WR: begin
               if (mem_done_w) begin
                  state_q <= (tmp_q == 32'h0000_0000) ? S_ENDP_IP : S_PICK;
               end
            end
            S_ENDP_IP: begin
               if (mem_done_w) begin
                  iptr_q <= dmem_rdata;
                  wptr_q <= a_q;
                  flush_q <= 1'b1;
                  state_q <= S_EXEC;
               end
            end
            default: begin
               state_q <= S_IDLE;
            end
         endcase
      end
   end

   // outputs straight from flip-flops
   assign dmem_req = req_q;
   assign dmem_we = we_q;
   assign dmem_addr = addr_q;
   assign dmem_wdata = wdata_q;
   assign wake_ready = wake_ready_q;
   assign running_pri = pri_q;
   assign running_wptr = wptr_q;
   assign iptr = iptr_q;
   assign oreg = oreg_q;
   assign stack_a = a_q;
   assign stack_b = b_q;
   assign stack_c = c_q;
   assign high_pri_list_front = front_q[PRI_HIGH];
   assign high_pri_list_back = back_q[PRI_HIGH];
   assign low_pri_list_front = front_q[PRI_LOW];
   assign low_pri_list_back = back_q[PRI_LOW];

   // idle flag registered apart from the state so it is a plain flop
   always_ff @(posedge core_clk or posedge rst) begin
      if (rst) begin
         idle <= 1'b1;
      end else begin
         idle <= (state_q == S_IDLE) & ~wake_take_w & ~pick_hi_w & ~pick_lo_w;
      end
   end
endmodule : process_scheduler_operate_decode

// ===== sched_chk.sv
`timescale 1ns/100ps
module sched_chk (
   input wire logic core_clk,
   input wire logic rst,
   input wire logic ifetch_req,
   input sched_pkg::word_t ifetch_addr,
   input wire logic ifetch_ack,
   input wire logic dmem_req,
   input wire logic dmem_we,
   input sched_pkg::word_t dmem_addr,
   input wire logic dmem_ack,
   input wire logic wake_valid,
   input wire logic wake_ready,
   input wire logic idle,
   input sched_pkg::word_t running_wptr,
   input sched_pkg::word_t high_pri_list_front,
   input sched_pkg::word_t high_pri_list_back,
   input sched_pkg::word_t low_pri_list_front,
   input sched_pkg::word_t low_pri_list_back
);
   import sched_pkg::*;

   default clocking cb @(posedge core_clk); endclocking
   default disable iff (rst);

   // handshake steps used by the properties; only s_wake_taken is shared by two
   sequence s_wake_taken;
      wake_valid && wake_ready;
   endsequence
   sequence s_dmem_wait;
      dmem_req && !dmem_ack;
   endsequence

   a_wake_ready_drop: assert property (
      s_wake_taken |=> !wake_ready)
      else $error("wake ready stayed high after accept");
   a_fetch_hold: assert property (
      ifetch_req && !ifetch_ack |=> ifetch_req && $stable(ifetch_addr))
      else $error("fetch request moved before ack");
   a_fetch_gap: assert property (
      ifetch_req && ifetch_ack |=> !ifetch_req)
      else $error("fetch request not released after ack");
   a_dmem_hold: assert property (
      s_dmem_wait |=> dmem_req && $stable(dmem_addr) && $stable(dmem_we))
      else $error("data request moved before ack");
   a_dmem_gap: assert property (
      dmem_req && dmem_ack |=> !dmem_req)
      else $error("data request not released after ack");
   a_idle_none: assert property (
      idle |-> running_wptr == NIL_PTR)
      else $error("idle while a process is running");
   a_high_list_pair: assert property (
      (high_pri_list_front == NIL_PTR) == (high_pri_list_back == NIL_PTR))
      else $error("high list front and back disagree");
   a_low_list_pair: assert property (
      (low_pri_list_front == NIL_PTR) == (low_pri_list_back == NIL_PTR))
      else $error("low list front and back disagree");
   a_idle_pick: assert property (
      idle and s_wake_taken |-> ##[1:8] !idle)
      else $error("woken process not picked from idle");
endmodule : sched_chk

bind process_scheduler_operate_decode sched_chk u_chk (.core_clk, .rst, .ifetch_req, .ifetch_addr,
   .ifetch_ack, .dmem_req, .dmem_we, .dmem_addr, .dmem_ack, .wake_valid, .wake_ready, .idle,
   .running_wptr, .high_pri_list_front, .high_pri_list_back, .low_pri_list_front,
   .low_pri_list_back);

// ===== tb_process_scheduler_operate_decode.sv
`timescale 1ns/100ps
module tb_process_scheduler_operate_decode;
   import sched_pkg::*;
   localparam word_t WS = 32'h0000_0020;
   logic core_clk = 1'b0, rst = 1'b1, ext_clk_in = 1'b0;
   logic ifetch_req, ifetch_ack = 1'b0, dmem_req, dmem_we, dmem_ack = 1'b0;
   logic wake_valid = 1'b0, wake_pri = 1'b0, wake_ready, idle, idle_seen = 1'b1, running_pri;
   word_t ifetch_addr, ifetch_rdata = '0, dmem_addr, dmem_wdata, dmem_rdata = '0;
   word_t wake_wptr = '0, stack_a, hf, hb, lf, lb;
   word_t stack_b, stack_c, running_wptr, iptr, oreg;
   word_t imem [64];
   word_t dmem [64];
   word_t exp_q [$];
   int err_count = 0, samples_checked = 0, cyc = 0;
   logic [15:0] lfsr = 16'h7C86;

   process_scheduler_operate_decode #(.SLICE_EDGES(4)) dut_u (.core_clk, .rst, .ext_clk_in,
      .ifetch_req, .ifetch_addr, .ifetch_ack, .ifetch_rdata, .dmem_req, .dmem_we, .dmem_addr,
      .dmem_wdata, .dmem_ack, .dmem_rdata, .wake_valid, .wake_wptr, .wake_pri, .wake_ready,
      .idle, .running_pri, .running_wptr, .iptr, .oreg, .stack_a, .stack_b,
      .stack_c, .high_pri_list_front(hf), .high_pri_list_back(hb), .low_pri_list_front(lf),
      .low_pri_list_back(lb));

   initial begin
      forever #4 core_clk = ~core_clk;
   end

   function automatic logic [15:0] lfsr_next(input logic [15:0] s);
      return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
   endfunction : lfsr_next

   task automatic check_val(input word_t seen, input word_t exp);
      samples_checked++;
      if (seen !== exp) begin
         err_count++;
         $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
      end
   endtask : check_val

   task automatic report_and_stop();
      $display("checks %0d mismatches %0d", samples_checked, err_count);
      if (err_count == 0 && samples_checked > 0) $display("Testbench passed");
      else $display("Testbench failed");
      $finish;
   endtask : report_and_stop

   // memory partner: one cycle latency, ack only while a request stands
   always @(posedge core_clk) begin
      cyc <= cyc + 1;
      if (cyc % 12 == 11) ext_clk_in <= ~ext_clk_in;
      ifetch_ack <= ifetch_req && !ifetch_ack;
      ifetch_rdata <= ifetch_ack ? ~ifetch_rdata : imem[ifetch_addr[5:0]];
      dmem_ack <= dmem_req && !dmem_ack;
      dmem_rdata <= dmem_ack ? ~dmem_rdata : dmem[dmem_addr[5:0]];
      if (dmem_req && !dmem_ack && dmem_we) dmem[dmem_addr[5:0]] <= dmem_wdata;
      if (cyc > 20000) begin
         err_count++;
         report_and_stop();
      end
   end

   // monitor: each return to idle closes one run, oldest note first
   always @(posedge core_clk) begin
      idle_seen <= idle;
      if (!rst && idle === 1'b1 && idle_seen === 1'b0 && exp_q.size() > 0) begin
         check_val(stack_a, exp_q.pop_front());
         check_val(dmem[WS[5:0] - 6'd1], 32'h0000_0046);
      end
   end

   task automatic wake(input word_t w, input logic pri);
      wake_wptr <= w;
      wake_pri <= pri;
      wake_valid <= 1'b1;
      @(posedge core_clk);
      for (int i = 0; i < 100 && wake_ready !== 1'b1; i++) @(posedge core_clk);
      check_val({31'h0, wake_ready}, 32'h1);
      wake_valid <= 1'b0;
      wake_wptr <= ~w;
   endtask : wake

   initial begin
      logic [3:0] a, b;
      foreach (imem[i]) imem[i] = '0;
      foreach (dmem[i]) dmem[i] = '0;
      repeat (5) @(posedge core_clk);
      rst <= 1'b0;
      @(posedge core_clk);
      // lists start empty on both priorities
      check_val(hf, NIL_PTR);
      check_val(lb, NIL_PTR);
      for (int r = 0; r < 6; r++) begin
         lfsr = lfsr_next(lfsr);
         a = lfsr[3:0];
         b = lfsr[7:4];
         dmem[WS[5:0] - 6'd1] = 32'h0000_0040;
         // odd rounds build the operand through a prefix and jump over a stray load
         if (r % 2 == 1) begin
            imem[16] = {8'h41, 8'h01, FN_LDC, b, FN_PFIX, a};
            exp_q.push_back({24'h0, a, b});
         end else begin
            imem[16] = {8'hF0, 8'hF5, FN_LDC, b, FN_LDC, a};
            exp_q.push_back(32'(a) + 32'(b));
         end
         imem[17] = 32'h0000_F521;
         wake(WS, r[1]);
         for (int i = 0; i < 2000 && exp_q.size() > 0; i++) @(posedge core_clk);
         check_val(32'(exp_q.size()), 32'h0);
         repeat (2) @(posedge core_clk);
         check_val(hf, NIL_PTR);
         check_val(lf, NIL_PTR);
         check_val({31'h0, idle}, 32'h1);
         check_val(running_wptr, NIL_PTR);
         check_val(iptr, 32'h0000_0046);
         check_val(oreg, 32'h0000_0000);
         check_val({31'h0, running_pri}, {31'h0, r[1]});
         $display("round %0d done", r);
      end
      // parent starts a child at workspace 0C, both end; the last end resumes the parent
      dmem[WS[5:0] - 6'd1] = 32'h0000_0048;
      dmem[WS[5:0]] = 32'h0000_0044;
      dmem[WS[5:0] + 6'h01] = 32'h0000_0002;
      imem[18] = 32'h22FD_4C40;
      imem[19] = 32'h0000_F340;
      exp_q.push_back(WS);
      // list pointers are only ever moved by the block itself
      wake(WS, PRI_HIGH);
      for (int i = 0; i < 2000 && exp_q.size() > 0; i++) @(posedge core_clk);
      repeat (2) @(posedge core_clk);
      check_val(32'(exp_q.size()), 32'h0);
      check_val(dmem[6'h0B], 32'h0000_004B);
      check_val(dmem[WS[5:0] + 6'h01], 32'h0000_0000);
      check_val(stack_b, WS);
      check_val(stack_c, 32'h0000_000C);
      check_val(hb, NIL_PTR);
      $display("parallel pair done");
      report_and_stop();
   end
endmodule : tb_process_scheduler_operate_decode
